// File: inc/rx_fmt_defines.vh
// constants for the receive system-side output formatter
// assumes inclusion by bare name from design files
`ifndef RX_FMT_DEFINES_VH
`define RX_FMT_DEFINES_VH
// channel count, numbered 0..16
`define RXF_NUM_CH 17
// format codes
`define RXF_FMT_SR_NRZ 2'h0
`define RXF_FMT_DR_NRZ 2'h1
`define RXF_FMT_DR_RZ 2'h2
`define RXF_FMT_DR_SLC 2'h3
// field positions in the configuration bytes
`define RXF_CFG0_PD_OUT 6
`define RXF_CFG0_POWER_OFF 5
`define RXF_CFG1_INV 3
`define RXF_CFG1_EDGE 4
`define RXF_CFG1_MF_HI 7
`define RXF_CFG1_MF_LO 5
// reset values of the configuration bytes
`define RXF_CFG0_RST 8'h00
`define RXF_CFG1_RST 8'h00
// multi-function selections
`define RXF_MF_PATTERN 3'h0
`define RXF_MF_AIS 3'h1
`define RXF_MF_EXZ 3'h2
`define RXF_MF_BPV 3'h3
`define RXF_MF_EXZ_BPV 3'h4
`define RXF_MF_LOS 3'h5
`define RXF_MF_RCLK 3'h6
`define RXF_MF_XOR 3'h7
// rate reference: rates in kHz, system clock in kHz, phase accumulator width
`define RXF_SYS_KHZ 25000
`define RXF_T1_KHZ 1544
`define RXF_E1_KHZ 2048
`define RXF_ACC_W 16
`endif

// File: src/rx_fmt_channel.v
// one channel of the receive system-side output formatter
// assumes recovered clock, rails and indications arrive asynchronous to i_sys_clk
`timescale 1ns/1ps
`include "rx_fmt_defines.vh"
module rx_fmt_channel (
   // clock and reset
   input wire i_sys_clk,
   input wire i_nrst,
   // line side, asynchronous
   input wire i_recovered_rx_clock,
   input wire i_nrz_data,
   input wire i_pos_rail,
   input wire i_neg_rail,
   input wire i_arbitrary_pattern_detect,
   input wire i_alarm_indication_detect,
   input wire i_excess_zeros_detect,
   input wire i_bipolar_violation_detect,
   input wire i_line_signal_loss,
   // configuration
   input wire [1:0] i_format,
   input wire [7:0] i_rx_config_first,
   input wire [7:0] i_rx_config_second,
   // pins
   output reg o_pin_a,
   output reg o_pin_a_oe_n,
   output reg o_pin_b,
   output reg o_pin_b_oe_n
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   reg [8:0] sync1_q;
   reg [8:0] sync2_q;
   reg rclk_prev_q;
   always @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         sync1_q <= 9'h000;
         sync2_q <= 9'h000;
         rclk_prev_q <= 1'b0;
      end else begin
         sync1_q <= {i_line_signal_loss, i_bipolar_violation_detect, i_excess_zeros_detect,
                     i_alarm_indication_detect, i_arbitrary_pattern_detect, i_neg_rail,
                     i_pos_rail, i_nrz_data, i_recovered_rx_clock};
         sync2_q <= sync1_q;
         rclk_prev_q <= sync2_q[0];
      end
   end
   wire rclk_s = sync2_q[0];
   wire nrz_s = sync2_q[1];
   wire pos_s = sync2_q[2];
   wire neg_s = sync2_q[3];
   wire edge_sel = i_rx_config_second[`RXF_CFG1_EDGE];
   wire inv = i_rx_config_second[`RXF_CFG1_INV];
   wire [2:0] mf_sel = i_rx_config_second[`RXF_CFG1_MF_HI:`RXF_CFG1_MF_LO];
   wire power_off = i_rx_config_first[`RXF_CFG0_POWER_OFF];
   wire pd_hiz = i_rx_config_first[`RXF_CFG0_PD_OUT];
   // edge select: 1 picks falling, 0 rising
   wire act_edge = edge_sel ? (rclk_prev_q & ~rclk_s) : (~rclk_prev_q & rclk_s);
   // ----------------------------------------
   // multi-function mux, active high always
   // ----------------------------------------
   reg mf_d;
   always @* begin
      case (mf_sel)
         `RXF_MF_PATTERN: mf_d = sync2_q[4];
         `RXF_MF_AIS: mf_d = sync2_q[5];
         `RXF_MF_EXZ: mf_d = sync2_q[6];
         `RXF_MF_BPV: mf_d = sync2_q[7];
         `RXF_MF_EXZ_BPV: mf_d = sync2_q[6] | sync2_q[7];
         `RXF_MF_LOS: mf_d = sync2_q[8];
         `RXF_MF_RCLK: mf_d = rclk_s;
         default: mf_d = pos_s ^ neg_s;
      endcase
   end
   // ----------------------------------------
   // output stage: format and pin mux switch in one register update
   // ----------------------------------------
   // sliced rails and a clock selection on the second pin follow each cycle; others wait for the active edge.
   // format change takes effect at the next update; both pins move together except when the second pin carries the clock selection
   always @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_pin_a <= 1'b0;
         o_pin_b <= 1'b0;
         o_pin_a_oe_n <= 1'b1;
         o_pin_b_oe_n <= 1'b1;
      end else if (power_off) begin
         o_pin_a <= 1'b0;
         o_pin_b <= 1'b0;
         o_pin_a_oe_n <= pd_hiz;
         o_pin_b_oe_n <= pd_hiz;
      end else begin
         o_pin_a_oe_n <= 1'b0;
         o_pin_b_oe_n <= 1'b0;
         if (i_format == `RXF_FMT_SR_NRZ) begin
            if (act_edge) begin
               o_pin_a <= nrz_s ^ inv;
            end
            // a clock selection must follow the clock; edge sampling alone
            // would freeze the pin at one level
            if (act_edge || mf_sel == `RXF_MF_RCLK) begin
               o_pin_b <= mf_d;
            end
         end else if (act_edge || i_format == `RXF_FMT_DR_SLC) begin
            // rails already oriented by the slicer (tip positive = pos rail)
            o_pin_a <= pos_s ^ inv;
            o_pin_b <= neg_s ^ inv;
         end
      end
   end
endmodule

// File: src/rx_output_formatter.v
// receive system-side output formatter for seventeen channels
// assumes line-side signals come from recovery logic in other clock domains
`timescale 1ns/1ps
`include "rx_fmt_defines.vh"
module rx_output_formatter (
   // clock and reset
   input wire i_sys_clk,
   input wire i_nrst,
   // rate mode: 1 = E1, 0 = T1/J1
   input wire i_e1_mode,
   // line side, one bit per channel
   input wire [16:0] i_recovered_rx_clock,
   input wire [16:0] i_nrz_data,
   input wire [16:0] i_rx_line_tip_pos,
   input wire [16:0] i_rx_line_tip_neg,
   input wire [16:0] i_arbitrary_pattern_detect,
   input wire [16:0] i_alarm_indication_detect,
   input wire [16:0] i_excess_zeros_detect,
   input wire [16:0] i_bipolar_violation_detect,
   input wire [16:0] i_line_signal_loss,
   // configuration, packed per channel
   input wire [33:0] i_format,
   input wire [135:0] i_rx_config_first,
   input wire [135:0] i_rx_config_second,
   // first pin: single_rail_rx_data / positive_rail_rx_data
   output wire [16:0] o_positive_rail_rx_data,
   output wire [16:0] o_positive_rail_rx_data_oe_n,
   // second pin: negative_rail_rx_data / rx_multi_function_out
   output wire [16:0] o_negative_rail_rx_data,
   output wire [16:0] o_negative_rail_rx_data_oe_n,
   // rate reference enable
   output reg o_derived_rate_clock
);
   // ----------------------------------------
   // rate reference from the system clock
   // ----------------------------------------
   // phase accumulator: step = rate * 2^W / sys; jitter is one sys clock, a
   // trade for keeping one clock domain
   localparam integer STEP_T1_FULL = (`RXF_T1_KHZ * 65536) / `RXF_SYS_KHZ;
   localparam integer STEP_E1_FULL = (`RXF_E1_KHZ * 65536) / `RXF_SYS_KHZ;
   // both steps fit the accumulator, so the upper bits are cut on purpose
   localparam [`RXF_ACC_W-1:0] STEP_T1 = STEP_T1_FULL[`RXF_ACC_W-1:0];
   localparam [`RXF_ACC_W-1:0] STEP_E1 = STEP_E1_FULL[`RXF_ACC_W-1:0];
   reg [`RXF_ACC_W-1:0] acc_q;
   wire [`RXF_ACC_W:0] acc_sum = {1'b0, acc_q} + {1'b0, (i_e1_mode ? STEP_E1 : STEP_T1)};
   always @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         acc_q <= {`RXF_ACC_W{1'b0}};
         o_derived_rate_clock <= 1'b0;
      end else begin
         acc_q <= acc_sum[`RXF_ACC_W-1:0];
         o_derived_rate_clock <= acc_sum[`RXF_ACC_W];
      end
   end
   // ----------------------------------------
   // per-channel output stages
   // ----------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < `RXF_NUM_CH; ch = ch + 1) begin : g_ch
         rx_fmt_channel u_ch (
            .i_sys_clk(i_sys_clk),
            .i_nrst(i_nrst),
            .i_recovered_rx_clock(i_recovered_rx_clock[ch]),
            .i_nrz_data(i_nrz_data[ch]),
            .i_pos_rail(i_rx_line_tip_pos[ch]),
            .i_neg_rail(i_rx_line_tip_neg[ch]),
            .i_arbitrary_pattern_detect(i_arbitrary_pattern_detect[ch]),
            .i_alarm_indication_detect(i_alarm_indication_detect[ch]),
            .i_excess_zeros_detect(i_excess_zeros_detect[ch]),
            .i_bipolar_violation_detect(i_bipolar_violation_detect[ch]),
            .i_line_signal_loss(i_line_signal_loss[ch]),
            .i_format(i_format[2*ch+1:2*ch]),
            .i_rx_config_first(i_rx_config_first[8*ch+7:8*ch]),
            .i_rx_config_second(i_rx_config_second[8*ch+7:8*ch]),
            .o_pin_a(o_positive_rail_rx_data[ch]),
            .o_pin_a_oe_n(o_positive_rail_rx_data_oe_n[ch]),
            .o_pin_b(o_negative_rail_rx_data[ch]),
            .o_pin_b_oe_n(o_negative_rail_rx_data_oe_n[ch])
         );
      end
   endgenerate
endmodule

// File: tb/rx_fmt_props.sv
// checker for the receive output formatter: channel 0 pins and rate pulse
// assumes line data holds steady around each active recovered edge
`timescale 1ns/1ps
module rx_fmt_props (
   // clock and reset
   input wire i_sys_clk,
   input wire i_nrst,
   // line side and configuration
   input wire [16:0] i_recovered_rx_clock,
   input wire [16:0] i_nrz_data,
   input wire [16:0] i_rx_line_tip_pos,
   input wire [16:0] i_rx_line_tip_neg,
   input wire [33:0] i_format,
   input wire [135:0] i_rx_config_first,
   input wire [135:0] i_rx_config_second,
   // pins
   input wire [16:0] o_positive_rail_rx_data,
   input wire [16:0] o_positive_rail_rx_data_oe_n,
   input wire [16:0] o_negative_rail_rx_data,
   input wire [16:0] o_negative_rail_rx_data_oe_n,
   input wire o_derived_rate_clock
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   // ----
   // channel 0 view
   // ----
   wire pa = o_positive_rail_rx_data[0];
   wire pb = o_negative_rail_rx_data[0];
   wire pa_z = o_positive_rail_rx_data_oe_n[0];
   wire pb_z = o_negative_rail_rx_data_oe_n[0];
   wire off = i_rx_config_first[5];
   wire hz = i_rx_config_first[6];
   wire inv = i_rx_config_second[3];
   wire sr = i_format[1:0] == 2'h0;
   wire rc = i_recovered_rx_clock[0];
   wire rt = o_derived_rate_clock;
   reg rc_q;
   // raw edge seen at the same clock as the design's first flop, so the two
   // sync stages plus the output register always put the pins three clocks on
   always @(posedge i_sys_clk) rc_q <= rc;
   wire act = !off && (i_rx_config_second[4] ? rc_q && !rc : !rc_q && rc);
   // expected levels, sampled at the edge and looked up three clocks later
   wire sr_exp = i_nrz_data[0] ^ inv;
   wire pos_exp = i_rx_line_tip_pos[0] ^ inv;
   wire neg_exp = i_rx_line_tip_neg[0] ^ inv;
   sr_data_a: assert property (act && sr |-> ##3 pa == $past(sr_exp, 3))
      else $error("single rail data wrong");
   dr_pos_a: assert property (act && !sr |-> ##3 pa == $past(pos_exp, 3))
      else $error("positive rail wrong");
   dr_neg_a: assert property (act && !sr |-> ##3 pb == $past(neg_exp, 3))
      else $error("negative rail wrong");
   pd_pin_a_a: assert property ($past(i_nrst) && $past(off) |-> !pa && pa_z == $past(hz))
      else $error("powered down first pin wrong");
   pd_pin_b_a: assert property ($past(i_nrst) && $past(off) |-> !pb && pb_z == $past(hz))
      else $error("powered down second pin wrong");
   drive_on_a: assert property (act ##1 (!off)[*6] |-> !pa_z && !pb_z)
      else $error("pins not driven");
   pair_oe_a: assert property (pa_z == pb_z) else $error("pin enables differ");
   // clocks since the last rate pulse; both step sizes keep the spacing
   // within 12 to 17 clocks, also across a mode change
   reg [4:0] gap_q;
   always @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         gap_q <= 5'h00;
      end else if (rt) begin
         gap_q <= 5'h01;
      end else if (gap_q != 5'h1F) begin
         gap_q <= gap_q + 5'h01;
      end
   end
   rate_gap_a: assert property (rt |-> gap_q >= 5'h0C && gap_q <= 5'h11)
      else $error("rate pulse spacing wrong");
   rate_late_a: assert property (gap_q <= 5'h11)
      else $error("rate pulse missing");
   cover property (act && sr);
   cover property (act && !sr && inv);
   cover property ($past(off) && hz);
endmodule
bind rx_output_formatter rx_fmt_props u_rx_fmt_props (.i_sys_clk, .i_nrst,
   .i_recovered_rx_clock, .i_nrz_data, .i_rx_line_tip_pos, .i_rx_line_tip_neg, .i_format,
   .i_rx_config_first, .i_rx_config_second, .o_positive_rail_rx_data,
   .o_positive_rail_rx_data_oe_n, .o_negative_rail_rx_data, .o_negative_rail_rx_data_oe_n,
   .o_derived_rate_clock);

// File: tb/rx_line_source.sv
// line-side stand-in: recovered clock, 320 ns period
// assumes the bench raises i_run after reset
`timescale 1ns/1ps
module rx_line_source (
   // control
   input wire i_run,
   // recovered clock, parked low while stopped
   output reg o_recovered_rx_clock
);
   // odd offset keeps its edges clear of the system clock edges
   initial begin
      o_recovered_rx_clock = 1'b0;
      #7;
      forever #160 o_recovered_rx_clock = i_run ? ~o_recovered_rx_clock : 1'b0;
   end
endmodule

// File: tb/rx_output_formatter_test.sv
// bench for the receive output formatter: channels alike, channel 1 powered down
// assumes rx_line_source gives the recovered clock and the checker is bound
`timescale 1ns/1ps
module rx_output_formatter_test;
   // ----
   // stimulus
   // ----
   reg clk = 1'b0, rst_n = 1'b0, e1 = 1'b0, run = 1'b0, nrz = 1'b0, p = 1'b0, n = 1'b0;
   reg a_x, b_x;
   reg [1:0] fmt = 2'h0;
   reg [4:0] ind = 5'h00;
   reg [7:0] c0 = 8'h00, c0b = 8'h00, c1 = 8'h00, mf;
   integer err_total = 0, n_checks = 0, f, j, k, cnt;
   wire rc, rate;
   wire [16:0] pa, pa_z, pb, pb_z;
   always #20 clk = ~clk;
   rx_line_source u_rx_line_source (.i_run(run), .o_recovered_rx_clock(rc));
   rx_output_formatter u_rx_output_formatter (.i_sys_clk(clk), .i_nrst(rst_n), .i_e1_mode(e1),
      .i_recovered_rx_clock({17{rc}}), .i_nrz_data({17{nrz}}), .i_rx_line_tip_pos({17{p}}),
      .i_rx_line_tip_neg({17{n}}), .i_arbitrary_pattern_detect({17{ind[0]}}),
      .i_alarm_indication_detect({17{ind[1]}}), .i_excess_zeros_detect({17{ind[2]}}),
      .i_bipolar_violation_detect({17{ind[3]}}), .i_line_signal_loss({17{ind[4]}}),
      .i_format({17{fmt}}), .i_rx_config_first({{15{c0}}, c0b, c0}),
      .i_rx_config_second({17{c1}}), .o_positive_rail_rx_data(pa),
      .o_positive_rail_rx_data_oe_n(pa_z), .o_negative_rail_rx_data(pb),
      .o_negative_rail_rx_data_oe_n(pb_z), .o_derived_rate_clock(rate));
   task check(input [33:0] seen, input [33:0] exp, input [63:0] what);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("mismatch %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task conclude;
      begin
         if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // watchdog: the run needs about 250 us
   initial begin
      #500000;
      err_total = err_total + 1;
      conclude;
   end
   initial begin
      repeat (10) @(negedge clk);
      check({pa | pb, pa_z & pb_z}, {17'h0, 17'h1FFFF}, "reset");
      rst_n = 1'b1;
      run = 1'b1;
      // every format, invert and edge; settings move only in the inactive half
      for (k = 0; k < 64; k = k + 1) begin
         if (c1[4]) @(posedge rc);
         else @(negedge rc);
         @(negedge clk);
         f = k / 4;
         j = f[1] * 4 + k % 4;
         fmt = f[3:2];
         c1 = {j[2:0], f[0], f[1], 3'h0};
         {nrz, p, n} = k[2:0] ^ f[2:0];
         ind = k[4:0] + 5'h0B;
         c0b = {1'b0, k[0], 6'h20};
         if (c1[4]) @(negedge rc);
         else @(posedge rc);
         repeat (6) @(negedge clk);
         mf = {p ^ n, ~c1[4], ind[4], ind[2] | ind[3], ind[3:0]}; // pins still show the clock's active phase, three clocks behind
         a_x = (fmt == 2'h0 ? nrz : p) ^ c1[3];
         b_x = fmt == 2'h0 ? mf[c1[7:5]] : n ^ c1[3];
         check({pa, pb}, {{15{a_x}}, 1'b0, a_x, {15{b_x}}, 1'b0, b_x}, "pins");
         check({pa_z, pb_z}, {2{15'h0, c0b[6], 1'b0}}, "enables");
      end
      // every channel powered down: pins driven low first, then high-impedance
      for (k = 0; k < 2; k = k + 1) begin
         @(negedge clk);
         c0 = {1'b0, k[0], 6'h20};
         c0b = c0;
         repeat (3) @(negedge clk);
         check({pa | pb, k ? pa_z & pb_z : pa_z | pb_z}, {17'h0, {17{k[0]}}}, "pd");
      end
      c0 = 8'h00;
      // accumulator phase unknown, so one pulse either way over 2500 cycles
      for (k = 0; k < 2; k = k + 1) begin
         @(negedge clk);
         e1 = k[0];
         cnt = 0;
         repeat (2500) @(negedge clk) cnt = cnt + rate;
         check(cnt == (k ? 204 : 154) || cnt == (k ? 205 : 155), 34'h1, "rate");
      end
      conclude;
   end
endmodule
